// File: logic/kpi_top.sv
// Keypad pin interrupt unit: detection, request latch and CPU side
//
// Overview of operation
// (R1) Five keypad inputs, each enabled by its own pin enable bit.
// (R2) An enabled pin also gets its internal pullup switched on.
// (R3) Request latches when an enabled pin falls after all were high.
// (R4) Edge-only mode: no request if another enabled pin already low.
// (R5) Edge-and-level: clears after acknowledge and all pins high.
// (R6) Sensitivity bit: 1 edge plus level, 0 edge only; reset clears.
// (R7) Vector fetch or writing 1 to acknowledge bit clears request.
// (R8) Edge-only mode: acknowledge clears the request at once.
// (R9) A falling edge after an acknowledge latches a new request.
// (R10) Unmasked pending request goes to CPU, vector at FFE4/FFE5.
// (R11) Reset clears request and sensitivity bit even with pin low.
// (R12) Pending flag reads 1 while request pending, mask ignored.
// (R13) Enabled pin is forced input; level readable only if direction 0.
// (R14) Software masks, enables, acknowledges, then unmasks at startup.
// (R15) Unit stays active in wait and stop; unmasked request wakes.
// (R16) In break, acknowledge clears flag only with break clear enable.
// (R17) Status bits 7 to 4 and acknowledge bit read as zero.
// (R18) Mask bit 1 blocks requests to CPU; reset clears it.
// (R19) Enable bit 1 lets its pin latch; reset clears all enables.
// (R20) Alternatively drive pins high as outputs before enabling them.
// (R21) Each input passes two flip-flops before detection.
`include "kpi_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module kpi_top (
	input wire logic mclk,
	input wire logic arst_n,
	input wire kpi_pkg::kpi_bus_s bus,
	output logic [7:0] rdata,
	input wire kpi_pkg::kpi_cpu_s cpu,
	input wire logic [`KPI_NPINS-1:0] keypad_input_pins,
	input wire logic [`KPI_NPINS-1:0] port_direction_register,
	input wire logic [`KPI_NPINS-1:0] port_data_out,
	output logic [`KPI_NPINS-1:0] pin_out,
	output logic [`KPI_NPINS-1:0] pin_oe,
	output logic [`KPI_NPINS-1:0] pullup_en,
	output logic [`KPI_NPINS-1:0] pin_read_level,
	output logic irq_req,
	output logic wake_req
);
	logic [`KPI_NPINS-1:0] pin_s;
	logic mode_r;
	logic mask_r;
	logic [`KPI_NPINS-1:0] pen_r;
	logic ack_wr;
	logic all_high_r;
	logic req_r;
	logic ack_pend_r;
	logic req_nxt;
	logic ack_pend_nxt;
	kpi_pkg::kpi_lvl_e st_r;

	////////////////////////////////////////////////////////////////////////
	kpi_sync u_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.pin_in(keypad_input_pins),
		.pin_sync(pin_s)
	);

	kpi_regs u_regs (
		.mclk(mclk),
		.arst_n(arst_n),
		.bus(bus),
		.pend(req_r),
		.rdata(rdata),
		.mode_r(mode_r),
		.mask_r(mask_r),
		.pen_r(pen_r),
		.ack_wr(ack_wr)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin side
	assign pullup_en = pen_r; // R2
	// Enable overrides the direction bit, so the pin becomes input
	wire [`KPI_NPINS-1:0] drive = port_direction_register & ~pen_r; // R13
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pin_oe <= '0;
			pin_out <= '0;
			pin_read_level <= '0;
		end else begin
			pin_oe <= drive; // R13
			pin_out <= port_data_out & drive;
			pin_read_level <= pin_s & ~port_direction_register; // R13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Detection
	wire any_low = |(~pin_s & pen_r); // R1 R19
	// Falling event only when all enabled pins were high last cycle
	wire fall = any_low && all_high_r; // R3 R4 R9
	// Acknowledge from vector fetch or write; break may block the write
	wire sw_ack = ack_wr && (!cpu.brk_state || cpu.brk_clr_en); // R16
	wire ack = sw_ack || cpu.vec_fetch; // R7

	always_comb begin
		req_nxt = req_r;
		ack_pend_nxt = ack_pend_r;
		if (!mode_r) begin
			ack_pend_nxt = 1'b0;
			if (ack)
				req_nxt = 1'b0; // R8
		end else begin
			if (ack && req_r)
				ack_pend_nxt = 1'b1; // R5
			if (ack_pend_nxt && !any_low) begin
				req_nxt = 1'b0; // R5
				ack_pend_nxt = 1'b0;
			end
		end
		// A new fall wins over a simultaneous acknowledge
		if (fall) begin
			req_nxt = 1'b1; // R3 R9
			ack_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			all_high_r <= 1'b1;
			req_r <= 1'b0; // R11
			ack_pend_r <= 1'b0;
		end else begin
			all_high_r <= !any_low;
			req_r <= req_nxt;
			ack_pend_r <= ack_pend_nxt;
		end
	end

	// Level-mode status view, kept for debug visibility of the sequence
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			st_r <= kpi_pkg::KPI_IDLE;
		else begin
			unique case (1'b1)
				!req_nxt: st_r <= kpi_pkg::KPI_IDLE;
				ack_pend_nxt: st_r <= kpi_pkg::KPI_ARMED;
				default: st_r <= kpi_pkg::KPI_HELD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// CPU side: request vectors to FFE4, also a wake source in wait/stop
	assign irq_req = req_r && !mask_r; // R10 R18
	assign wake_req = irq_req && (cpu.wait_mode || cpu.stop_mode); // R15

	////////////////////////////////////////////////////////////////////////
	// Check helpers: cycles since reset, so that checks on delayed copies
	// skip the reset values of the pipeline flops
	logic [1:0] settle_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			settle_r <= 2'h0;
		else if (settle_r != 2'h3)
			settle_r <= settle_r + 2'h1;
	end
	wire chk_sc_wr = bus.wr && (bus.addr == `KPI_OFF_SC);
	wire chk_pe_wr = bus.wr && (bus.addr == `KPI_OFF_PE);
	wire chk_sc_rd = bus.rd && (bus.addr == `KPI_OFF_SC);
	wire chk_pe_rd = bus.rd && (bus.addr == `KPI_OFF_PE);

	////////////////////////////////////////////////////////////////////////
	// Request latch and clear
	AST_FALL_LATCH: // R3
	assert property (@(posedge mclk) disable iff (!arst_n)
		fall |=> req_r)
		else $error("fall did not latch request");
	AST_EDGE_ACK: // R8
	assert property (@(posedge mclk) disable iff (!arst_n)
		(!mode_r && ack && !fall) |=> !req_r)
		else $error("edge mode ack did not clear");
	AST_LEVEL_HOLD: // R5
	assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_r && req_r && any_low) |=> req_r)
		else $error("level request dropped while pin low");
	AST_NO_FALL_LOW: // R4
	assert property (@(posedge mclk) disable iff (!arst_n)
		(!req_r && !all_high_r && !fall) |=> !req_r)
		else $error("request without edge from all high");
	AST_MASK: // R18
	assert property (@(posedge mclk) disable iff (!arst_n)
		mask_r |-> !irq_req)
		else $error("masked request reached cpu");
	AST_IRQ: // R10
	assert property (@(posedge mclk) disable iff (!arst_n)
		(req_r && !mask_r) |-> irq_req)
		else $error("unmasked request not presented");
	AST_BRK: // R16
	assert property (@(posedge mclk) disable iff (!arst_n)
		(cpu.brk_state && !cpu.brk_clr_en && !cpu.vec_fetch && req_r
		&& !ack_pend_r) |=> req_r)
		else $error("break write cleared protected flag");
	AST_PULLUP: // R2
	assert property (@(posedge mclk) disable iff (!arst_n)
		chk_pe_wr |=> (pullup_en == $past(bus.wdata[`KPI_NPINS-1:0])))
		else $error("pullup not following enable");
	AST_FORCE_IN: // R13
	assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(pen_r[0]) |=> !pin_oe[0])
		else $error("enabled pin still driven");
	AST_WAKE: // R15
	assert property (@(posedge mclk) disable iff (!arst_n)
		(irq_req && cpu.stop_mode) |-> wake_req)
		else $error("no wake from stop");

	// Every rise of the request has a fall behind it and every clear an
	// acknowledge, so no other path can touch the flag
	AST_REQ_CAUSE: // R3
	assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(req_r) |-> ($past(all_high_r) && $past(any_low)))
		else $error("request rose without a fall from all high");
	AST_FELL_CAUSE: // R7
	assert property (@(posedge mclk) disable iff (!arst_n)
		$fell(req_r) |-> ($past(ack) || $past(ack_pend_r)))
		else $error("request cleared without acknowledge");
	AST_LEVEL_CLEAR: // R5
	assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_r && ack_pend_r && !any_low) |=> !req_r)
		else $error("level request kept after ack and release");
	AST_LEVEL_ACK_HIGH: // R5
	assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_r && req_r && ack && !any_low) |=> !req_r)
		else $error("level ack with pins high did not clear");
	AST_BRK_CLR: // R16
	assert property (@(posedge mclk) disable iff (!arst_n)
		(cpu.brk_state && cpu.brk_clr_en && ack_wr && !mode_r && !fall)
		|=> !req_r)
		else $error("enabled break write did not clear flag");
	AST_VEC_ACK: // R7
	assert property (@(posedge mclk) disable iff (!arst_n)
		(cpu.vec_fetch && !mode_r && !fall) |=> !req_r)
		else $error("vector fetch did not clear request");
	AST_EDGE_NO_PEND: // R8
	assert property (@(posedge mclk) disable iff (!arst_n)
		!mode_r |=> !ack_pend_r)
		else $error("edge mode kept a pending acknowledge");
	AST_ACK_PEND_REQ: // R5
	assert property (@(posedge mclk) disable iff (!arst_n)
		ack_pend_r |-> req_r)
		else $error("pending acknowledge without request");
	AST_NO_PIN_NO_REQ: // R19
	assert property (@(posedge mclk) disable iff (!arst_n)
		(pen_r == 5'h00 && !req_r) |=> !req_r)
		else $error("request with no pin enabled");

	// Register view: a read shows the state of the cycle before, and
	// nothing but a write moves the control bits
	AST_SC_READ_ZERO: // R17
	assert property (@(posedge mclk) disable iff (!arst_n)
		$past(chk_sc_rd) |-> (rdata[7:4] == 4'h0 && !rdata[`KPI_BIT_ACK]))
		else $error("unused or acknowledge bit read as one");
	AST_PEND_READ: // R12
	assert property (@(posedge mclk) disable iff (!arst_n)
		$past(chk_sc_rd) |-> (rdata[`KPI_BIT_PEND] == $past(req_r)))
		else $error("pending flag read wrong");
	AST_MODE_READ: // R6
	assert property (@(posedge mclk) disable iff (!arst_n)
		$past(chk_sc_rd) |-> (rdata[`KPI_BIT_MODE] == $past(mode_r)))
		else $error("sensitivity bit read wrong");
	AST_MASK_READ: // R18
	assert property (@(posedge mclk) disable iff (!arst_n)
		$past(chk_sc_rd) |-> (rdata[`KPI_BIT_MASK] == $past(mask_r)))
		else $error("mask bit read wrong");
	AST_PE_READ: // R19
	assert property (@(posedge mclk) disable iff (!arst_n)
		$past(chk_pe_rd) |-> (rdata == {3'h0, $past(pen_r)}))
		else $error("pin enable read wrong");
	AST_MODE_WRITE: // R6
	assert property (@(posedge mclk) disable iff (!arst_n)
		chk_sc_wr |=> (mode_r == $past(bus.wdata[`KPI_BIT_MODE])))
		else $error("sensitivity write not taken");
	AST_MASK_WRITE: // R18
	assert property (@(posedge mclk) disable iff (!arst_n)
		chk_sc_wr |=> (mask_r == $past(bus.wdata[`KPI_BIT_MASK])))
		else $error("mask write not taken");
	AST_MODE_KEEP: // R6
	assert property (@(posedge mclk) disable iff (!arst_n)
		!chk_sc_wr |=> ($stable(mode_r) && $stable(mask_r)))
		else $error("control bits moved without a write");
	AST_PE_KEEP: // R2
	assert property (@(posedge mclk) disable iff (!arst_n)
		!chk_pe_wr |=> $stable(pullup_en))
		else $error("pullups moved without a write");

	// Pin side follows the port one cycle late; the pipeline reset
	// values are skipped through the settle count
	AST_OE_FOLLOW: // R13
	assert property (@(posedge mclk) disable iff (!arst_n)
		(settle_r != 2'h0) |->
		(pin_oe == $past(port_direction_register & ~pen_r)))
		else $error("output enable does not follow direction");
	AST_OUT_FOLLOW: // R13
	assert property (@(posedge mclk) disable iff (!arst_n)
		(settle_r != 2'h0) |-> (pin_out ==
		$past(port_data_out & port_direction_register & ~pen_r)))
		else $error("pin output does not follow port data");
	AST_READ_LEVEL: // R13
	assert property (@(posedge mclk) disable iff (!arst_n)
		(settle_r != 2'h0) |->
		(pin_read_level == $past(pin_s & ~port_direction_register)))
		else $error("pin level visible on an output pin");
	AST_SYNC_DELAY: // R21
	assert property (@(posedge mclk) disable iff (!arst_n)
		(settle_r == 2'h3) |-> (pin_s == $past(keypad_input_pins, 2)))
		else $error("synchroniser delay is not two cycles");

	// Status view agrees with the request and acknowledge flags,
	// so a debug read of it can be trusted
	AST_ST_ONEHOT: // R5
	assert property (@(posedge mclk) disable iff (!arst_n)
		$onehot(st_r))
		else $error("status view not one-hot");
	AST_ST_ARMED: // R5
	assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == kpi_pkg::KPI_ARMED) |-> (req_r && ack_pend_r))
		else $error("armed status without pending acknowledge");
	AST_ST_IDLE: // R5
	assert property (@(posedge mclk) disable iff (!arst_n)
		(st_r == kpi_pkg::KPI_IDLE) |-> !req_r)
		else $error("idle status with request set");

	// Wake only from a low-power mode, and never while masked, since a
	// masked request must not disturb the sleeping core
	AST_WAKE_WAIT: // R15
	assert property (@(posedge mclk) disable iff (!arst_n)
		(irq_req && cpu.wait_mode) |-> wake_req)
		else $error("no wake from wait");
	AST_NO_WAKE_RUN: // R15
	assert property (@(posedge mclk) disable iff (!arst_n)
		(!cpu.wait_mode && !cpu.stop_mode) |-> !wake_req)
		else $error("wake raised while running");
	AST_WAKE_MASKED: // R18
	assert property (@(posedge mclk) disable iff (!arst_n)
		mask_r |-> !wake_req)
		else $error("masked request woke the core");
endmodule : kpi_top
`default_nettype wire

// File: logic/kpi_consts.svh
// Register offsets, bit positions, reset values and widths of the keypad unit
`ifndef KPI_CONSTS_SVH
`define KPI_CONSTS_SVH
`define KPI_NPINS 5
`define KPI_ADDR_W 4
`define KPI_OFF_SC 4'h0
`define KPI_OFF_PE 4'h1
`define KPI_BIT_MODE 0
`define KPI_BIT_MASK 1
`define KPI_BIT_ACK 2
`define KPI_BIT_PEND 3
`define KPI_RST_SC 8'h00
`define KPI_RST_PE 5'h00
`define KPI_VEC_HI 16'hFFE4
`define KPI_VEC_LO 16'hFFE5
`endif

// File: logic/kpi_pkg.sv
// Types shared by the keypad interrupt unit
`default_nettype none
package kpi_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} kpi_bus_s;
	typedef struct packed {
		logic stop_mode;
		logic wait_mode;
		logic brk_state;
		logic brk_clr_en;
		logic vec_fetch;
	} kpi_cpu_s;
	typedef enum logic [2:0] {
		KPI_IDLE = 3'b001,
		KPI_HELD = 3'b010,
		KPI_ARMED = 3'b100
	} kpi_lvl_e;
endpackage : kpi_pkg
`default_nettype wire

// File: logic/kpi_sync.sv
// Two-flop synchroniser for the keypad input pins
`include "kpi_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module kpi_sync (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [`KPI_NPINS-1:0] pin_in,
	output logic [`KPI_NPINS-1:0] pin_sync
);
	logic [`KPI_NPINS-1:0] meta_r;
	genvar i;
	generate
		for (i = 0; i < `KPI_NPINS; i = i + 1) begin : g_sync
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					meta_r[i] <= 1'b1;
					pin_sync[i] <= 1'b1;
				end else begin
					meta_r[i] <= pin_in[i]; // R21
					pin_sync[i] <= meta_r[i]; // R21
				end
			end
		end
	endgenerate
endmodule : kpi_sync
`default_nettype wire

// File: logic/kpi_regs.sv
// Register file: status/control and pin enable registers
`include "kpi_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module kpi_regs (
	input wire logic mclk,
	input wire logic arst_n,
	input wire kpi_pkg::kpi_bus_s bus,
	input wire logic pend,
	output logic [7:0] rdata,
	output logic mode_r,
	output logic mask_r,
	output logic [`KPI_NPINS-1:0] pen_r,
	output logic ack_wr
);
	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction : hit
	wire sc_wr = bus.wr && hit(bus.addr, `KPI_OFF_SC);
	wire pe_wr = bus.wr && hit(bus.addr, `KPI_OFF_PE);
	wire [7:0] sc_rd = {4'h0, pend, 1'b0, mask_r, mode_r}; // R17 R12
	wire [7:0] pe_rd = {3'h0, pen_r};
	wire [7:0] rd_mux = hit(bus.addr, `KPI_OFF_SC) ? sc_rd :
		hit(bus.addr, `KPI_OFF_PE) ? pe_rd : 8'h00;
	assign ack_wr = sc_wr && bus.wdata[`KPI_BIT_ACK]; // R7
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= 1'b0; // R6 R11
			mask_r <= 1'b0; // R18
			pen_r <= `KPI_RST_PE; // R19
			rdata <= 8'h00;
		end else begin
			if (sc_wr) begin
				mode_r <= bus.wdata[`KPI_BIT_MODE]; // R6
				mask_r <= bus.wdata[`KPI_BIT_MASK]; // R18
			end
			if (pe_wr)
				pen_r <= bus.wdata[`KPI_NPINS-1:0]; // R1
			rdata <= bus.rd ? rd_mux : 8'h00;
		end
	end
endmodule : kpi_regs
`default_nettype wire

// File: sim/kpi_keys.sv
// Keypad switch model: pressed keys pull low, released keys float
`timescale 1ns/1ns
`default_nettype none
module kpi_keys (
	input wire logic mclk,
	input wire logic [4:0] press,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic [4:0] pullup_en,
	output logic [4:0] pins
);
	// A floating pin wanders so that a missing pullup cannot pass unseen
	logic [4:0] flt_r = 5'h00;
	always_ff @(posedge mclk) begin
		flt_r <= ~flt_r;
	end
	assign pins = (pin_oe & pin_out)
		| (~pin_oe & ~press & (pullup_en | flt_r));
endmodule : kpi_keys
`default_nettype wire

// File: sim/keypad_pin_interrupt_tb_top.sv
// Self-checking testbench of the keypad interrupt unit
`include "kpi_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module keypad_pin_interrupt_tb_top;
	localparam logic [3:0] sc_a = `KPI_OFF_SC;
	localparam logic [3:0] pe_a = `KPI_OFF_PE;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	kpi_pkg::kpi_bus_s bus = '0;
	kpi_pkg::kpi_cpu_s cpu = '0;
	logic [4:0] press = 5'h00;
	// Pins start as driven-high outputs so enabling raises no request
	logic [4:0] dir = 5'h1f;
	logic [4:0] dout = 5'h1f;
	logic [4:0] pins, pout, poe, pu, rl;
	logic [7:0] rdata;
	logic irq, wake;
	int failures = 0;
	int total_checks = 0;
	kpi_top DUT (.mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
		.cpu(cpu), .keypad_input_pins(pins), .port_direction_register(dir),
		.port_data_out(dout), .pin_out(pout), .pin_oe(poe), .pullup_en(pu),
		.pin_read_level(rl), .irq_req(irq), .wake_req(wake));
	kpi_keys KEYS (.mclk(mclk), .press(press), .pin_out(pout),
		.pin_oe(poe), .pullup_en(pu), .pins(pins));
	initial begin
		forever #4 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic w(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) bus <= '0;
	endtask : w
	task automatic r(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk) bus <= '0;
		#1 chk(rdata, e);
	endtask : r
	// Synchroniser plus detection take three edges
	task automatic key(input logic [4:0] p);
		@(posedge mclk) press <= p;
		repeat (6) @(posedge mclk);
		#1;
	endtask : key
	task automatic stop_test;
		if (failures == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		r(sc_a, `KPI_RST_SC);
		r(pe_a, {3'h0, `KPI_RST_PE});
		r(4'h7, 8'h00);
		chk({3'h0, pu}, 8'h00);
		chk({3'h0, poe}, 8'h1f);
		chk({3'h0, pout}, 8'h1f);
	endtask : t_reset
	task automatic t_init;
		w(sc_a, 8'h02);
		w(pe_a, 8'h1f);
		repeat (4) @(posedge mclk);
		w(sc_a, 8'h06);
		w(sc_a, 8'h00);
		r(pe_a, 8'h1f);
		r(sc_a, 8'h00);
		chk({3'h0, pu}, 8'h1f);
		chk({3'h0, poe}, 8'h00);
		chk({3'h0, pout}, 8'h00);
		chk({3'h0, rl}, 8'h00);
		@(posedge mclk) dir <= 5'h00;
		repeat (4) @(posedge mclk);
		#1 chk({3'h0, rl}, 8'h1f);
	endtask : t_init
	task automatic t_edge;
		key(5'h01);
		r(sc_a, 8'h08);
		chk({7'h00, irq}, 8'h01);
		w(sc_a, 8'h04);
		r(sc_a, 8'h00);
		key(5'h03);
		r(sc_a, 8'h00);
		key(5'h00);
	endtask : t_edge
	task automatic t_vec;
		w(sc_a, 8'h02);
		@(posedge mclk) cpu.wait_mode <= 1'b1;
		key(5'h04);
		r(sc_a, 8'h0a);
		chk({6'h00, wake, irq}, 8'h00);
		w(sc_a, 8'h00);
		#1 chk({6'h00, wake, irq}, 8'h03);
		@(posedge mclk) cpu <= 5'h01;
		@(posedge mclk) cpu <= 5'h10;
		r(sc_a, 8'h00);
		key(5'h00);
		key(5'h10);
		r(sc_a, 8'h08);
		chk({6'h00, wake, irq}, 8'h03);
		w(sc_a, 8'h04);
		@(posedge mclk) cpu <= '0;
		key(5'h00);
	endtask : t_vec
	task automatic t_level;
		w(sc_a, 8'h01);
		key(5'h08);
		w(sc_a, 8'h05);
		r(sc_a, 8'h09);
		key(5'h00);
		r(sc_a, 8'h01);
		key(5'h08);
		key(5'h00);
		r(sc_a, 8'h09);
		w(sc_a, 8'h05);
		r(sc_a, 8'h01);
	endtask : t_level
	task automatic t_brk;
		w(sc_a, 8'h00);
		key(5'h02);
		@(posedge mclk) cpu.brk_state <= 1'b1;
		w(sc_a, 8'h04);
		r(sc_a, 8'h08);
		@(posedge mclk) cpu.brk_clr_en <= 1'b1;
		w(sc_a, 8'h04);
		@(posedge mclk) cpu <= '0;
		r(sc_a, 8'h00);
		key(5'h00);
	endtask : t_brk
	task automatic t_rst;
		w(sc_a, 8'h01);
		key(5'h01);
		r(sc_a, 8'h09);
		@(posedge mclk) arst_n <= 1'b0;
		@(posedge mclk) arst_n <= 1'b1;
		r(sc_a, 8'h00);
		r(pe_a, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask : t_rst
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset;
		t_init;
		t_edge;
		t_vec;
		t_level;
		t_brk;
		t_rst;
		stop_test;
	end
	// The scenarios need about two hundred cycles; this bound only cuts a hang
	initial begin
		repeat (3000) @(posedge mclk);
		failures++;
		stop_test;
	end
endmodule : keypad_pin_interrupt_tb_top
`default_nettype wire
